// ==== tch_output_ctrl.sv ====
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ns
`include "tch_consts.svh"

// Overview of operation
// - level mode: output driven active while a detection is in effect
// - level mode: active until detection ends or hold timeout, whichever first
// - level timeout: full recalibration, output inactive until next detection
// - level mode offers 10 s, 60 s or no hold timeout
// - straps: HH level 10s, HL level 60s, LL toggle 10s, LH level none
// - no timeout: output follows detection, never recalibrates on length
// - toggle mode: each newly qualified detection inverts the output
// - toggle mode: hold timeout always 10 s of continuous detection
// - toggle timeout: recalibrate, keep toggled output state
// - after every burst, output released to high impedance for 300 us
// - health pulse present in every output mode, over the normal output
// - active-low variant: level modes drive output high while no detection present
// - active-high variant: inverted polarity, identical health pulse
// - straps sampled once at power-up select mode and timeout
// - three successive bursts above threshold qualify; any miss clears count
// - threshold sits 6 counts (gain high) or 12 counts above reference
// - detection ends below threshold minus 17 percent of the delta
module tch_output_ctrl
  import tch_pkg::*;
#(
  parameter int          SIG_W          = 16,
  parameter bit          ACTIVE_HIGH    = 1'b0,
  parameter int          HOLD_W         = 36,
  parameter longint      HOLD_SHORT_CYC = 64'(`TCH_HOLD_SHORT_S) * 64'(`TCH_CLK_HZ),
  parameter longint      HOLD_LONG_CYC  = 64'(`TCH_HOLD_LONG_S) * 64'(`TCH_CLK_HZ),
  parameter int          HB_CYC         = `TCH_HB_US * (`TCH_CLK_HZ / `TCH_US_PER_S),
  parameter int          HB_W           = 16
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // option straps, asynchronous pins
  input  wire logic             mode_strap_a_pin,
  input  wire logic             mode_strap_b_pin,
  input  wire logic             gain_strap_pin,
  // acquisition results, one per burst
  input  wire logic             burst_done,
  input  wire logic [SIG_W-1:0] burst_signal,
  input  wire logic [SIG_W-1:0] burst_reference,
  // recalibration handshake with the acquisition core
  output logic                  recal_req,
  input  wire logic             recal_done,
  // output pin and detection status
  output logic                  out_o,
  output logic                  out_oe,
  output logic                  detect_active,
  // register port
  input  wire logic [3:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata
);

  localparam int CW = SIG_W + 1;
  localparam logic [1:0] INTEG_LAST = 2'(`TCH_INTEG_COUNT - 1);
  localparam logic [2:0] SETTLE_LAST = 3'(`TCH_STRAP_SETTLE - 1);
  localparam logic [HOLD_W-1:0] HOLD_SHORT_LAST = HOLD_W'(HOLD_SHORT_CYC - 1);
  localparam logic [HOLD_W-1:0] HOLD_LONG_LAST  = HOLD_W'(HOLD_LONG_CYC - 1);

  if (HOLD_W < 32 || HOLD_LONG_CYC < 1 || HOLD_SHORT_CYC < 1
      || HOLD_LONG_CYC > (64'd1 << HOLD_W)
      || HOLD_SHORT_CYC > (64'd1 << HOLD_W)) begin : g_chk_hold
    $error("tch_output_ctrl: hold counts do not fit HOLD_W");
  end
  if (SIG_W < 8) begin : g_chk_sig
    $error("tch_output_ctrl: SIG_W too narrow");
  end

  // threshold delta and its hysteresis, both in signal counts
  function automatic logic [CW-1:0] delta_of(input logic gain_hi);
    delta_of = gain_hi ? CW'(`TCH_DELTA_GAIN_HI) : CW'(`TCH_DELTA_GAIN_LO);
  endfunction

  function automatic logic [CW-1:0] hyst_of(input logic gain_hi);
    logic [CW+7:0] prod;
    prod = (CW+8)'(delta_of(gain_hi)) * (CW+8)'(`TCH_HYST_PCT);
    hyst_of = CW'(prod / (CW+8)'(`TCH_PCT_FULL));
  endfunction

  function automatic tch_mode_type mode_of(input logic a, input logic b);
    case ({a, b})
      2'b11:   mode_of = TCH_MODE_LEVEL_10;
      2'b10:   mode_of = TCH_MODE_LEVEL_60;
      2'b00:   mode_of = TCH_MODE_TOGGLE_10;
      default: mode_of = TCH_MODE_LEVEL_INF;
    endcase
  endfunction

  // strap synchronisers
  logic strap_a_lvl;
  logic strap_b_lvl;
  logic gain_lvl;

  tch_sync u_sync_a (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_i   (mode_strap_a_pin),
    .level_o (strap_a_lvl)
  );

  tch_sync u_sync_b (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_i   (mode_strap_b_pin),
    .level_o (strap_b_lvl)
  );

  tch_sync u_sync_g (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_i   (gain_strap_pin),
    .level_o (gain_lvl)
  );

  // state
  tch_state_type     state_q;
  tch_state_type     state_d;
  tch_mode_type      mode_q;
  logic              gain_hi_q;
  logic              straps_ok_q;
  logic [2:0]        settle_q;
  logic [1:0]        integ_q;
  logic [1:0]        integ_d;
  logic [HOLD_W-1:0] hold_q;
  logic              tog_q;
  logic              out_q;
  logic              recal_req_q;
  logic              ev_timeout_q;
  logic              ev_qualify_q;
  logic [31:0]       rdata_q;
  logic              hb_busy;

  // register decode
  wire wr_ctrl  = reg_wr && (reg_addr == `TCH_REG_CTRL);
  wire wr_event = reg_wr && (reg_addr == `TCH_REG_EVENT);
  wire sw_recal = wr_ctrl && reg_wdata[`TCH_CTRL_RECAL];
  wire sw_tog_clr = wr_ctrl && reg_wdata[`TCH_CTRL_TOG_CLR];

  // threshold arithmetic, one bit wider than the signal
  wire [CW-1:0] sig_w   = {1'b0, burst_signal};
  wire [CW-1:0] thr_lvl = {1'b0, burst_reference} + delta_of(gain_hi_q);
  wire [CW-1:0] drop_lvl = thr_lvl - hyst_of(gain_hi_q);
  wire above_thr = (sig_w > thr_lvl);
  wire below_drop = (sig_w < drop_lvl);

  // mode decode
  wire toggle_mode = (mode_q == TCH_MODE_TOGGLE_10);
  wire has_limit   = (mode_q != TCH_MODE_LEVEL_INF);
  wire [HOLD_W-1:0] hold_last = (mode_q == TCH_MODE_LEVEL_60)
                                ? HOLD_LONG_LAST : HOLD_SHORT_LAST;

  wire in_detect = (state_q == TCH_ST_DETECT);
  wire expire    = in_detect && has_limit && (hold_q == hold_last);
  wire qualify   = (state_q == TCH_ST_IDLE) && burst_done && above_thr
                   && (integ_q == INTEG_LAST);
  wire det_end   = in_detect && burst_done && below_drop;

  // detection and recalibration sequencing
  always_comb begin
    state_d = state_q;
    integ_d = integ_q;
    case (state_q)
      TCH_ST_BOOT: begin
        if (settle_q == SETTLE_LAST) begin
          state_d = TCH_ST_IDLE;
        end
      end
      TCH_ST_IDLE: begin
        if (sw_recal) begin
          state_d = TCH_ST_RECAL;
          integ_d = 2'h0;
        end else if (burst_done) begin
          if (!above_thr) begin
            integ_d = 2'h0;
          end else if (integ_q == INTEG_LAST) begin
            integ_d = 2'h0;
            state_d = TCH_ST_DETECT;
          end else begin
            integ_d = integ_q + 2'h1;
          end
        end
      end
      TCH_ST_DETECT: begin
        if (expire || sw_recal) begin
          state_d = TCH_ST_RECAL;
        end else if (det_end) begin
          state_d = TCH_ST_IDLE;
        end
      end
      TCH_ST_RECAL: begin
        if (recal_done) begin
          state_d = TCH_ST_IDLE;
        end
      end
      default: begin
        state_d = TCH_ST_BOOT;
        integ_d = 2'h0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= TCH_ST_BOOT;
      integ_q <= 2'h0;
    end else begin
      state_q <= state_d;
      integ_q <= integ_d;
    end
  end

  // straps are caught once, after the synchronisers have settled
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      settle_q    <= 3'h0;
      straps_ok_q <= 1'b0;
      mode_q      <= TCH_MODE_LEVEL_10;
      gain_hi_q   <= 1'b1;
    end else if (state_q == TCH_ST_BOOT) begin
      settle_q <= settle_q + 3'h1;
      if (settle_q == SETTLE_LAST) begin
        straps_ok_q <= 1'b1;
        mode_q      <= mode_of(strap_a_lvl, strap_b_lvl);
        gain_hi_q   <= gain_lvl;
      end
    end
  end

  // hold timer runs only during a detection
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hold_q <= '0;
    end else if (state_d == TCH_ST_DETECT && in_detect && has_limit) begin
      hold_q <= hold_q + HOLD_W'(1);
    end else begin
      hold_q <= '0;
    end
  end

  // recalibration request, one cycle on entry to RECAL
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      recal_req_q <= 1'b0;
    end else begin
      recal_req_q <= (state_d == TCH_ST_RECAL) && (state_q != TCH_ST_RECAL);
    end
  end

  // toggle state survives a timeout recalibration
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tog_q <= 1'b0;
    end else if (qualify && toggle_mode && !sw_recal) begin
      tog_q <= !tog_q;
    end else if (sw_tog_clr) begin
      tog_q <= 1'b0;
    end
  end

  // polarity: the variant inverts the level, not the timing
  wire out_on = toggle_mode ? tog_q : in_detect;
  localparam logic OUT_IDLE = ACTIVE_HIGH ? 1'b0 : 1'b1;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_q <= OUT_IDLE;
    end else begin
      out_q <= ACTIVE_HIGH ? out_on : !out_on;
    end
  end

  // health pulse window restarts after every burst, in every mode
  tch_pulse_timer #(
    .CYC (HB_CYC),
    .W   (HB_W)
  ) u_hb (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start_i (burst_done),
    .busy_o  (hb_busy)
  );

  assign out_o  = out_q;
  assign out_oe = !hb_busy;
  assign detect_active = in_detect;
  assign recal_req = recal_req_q;

  // sticky events: a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ev_timeout_q <= 1'b0;
      ev_qualify_q <= 1'b0;
    end else begin
      ev_timeout_q <= expire
                      || (ev_timeout_q && !(wr_event && reg_wdata[`TCH_EV_TIMEOUT]));
      ev_qualify_q <= qualify
                      || (ev_qualify_q && !(wr_event && reg_wdata[`TCH_EV_QUALIFY]));
    end
  end

  // read data
  wire [31:0] status_word = {
    22'h0,
    straps_ok_q,
    gain_hi_q,
    mode_q,
    integ_q,
    state_q == TCH_ST_RECAL,
    hb_busy,
    out_on,
    in_detect
  };
  wire [31:0] event_word = {30'h0, ev_qualify_q, ev_timeout_q};
  wire [31:0] hold_word  = hold_q[HOLD_W-1 -: 32];
  wire [31:0] rd_mux =
      (reg_addr == `TCH_REG_STATUS) ? status_word :
      (reg_addr == `TCH_REG_EVENT)  ? event_word  :
      (reg_addr == `TCH_REG_HOLD)   ? hold_word   : 32'h0;

  // data stands one cycle after the read strobe and only then
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 32'h0;
    end
  end

  assign reg_rdata = rdata_q;

endmodule // tch_output_ctrl

// ==== tch_consts.svh ====
`ifndef TCH_CONSTS_SVH
`define TCH_CONSTS_SVH

// clock and timing
`define TCH_CLK_HZ          100000000
`define TCH_HOLD_SHORT_S    10
`define TCH_HOLD_LONG_S     60
`define TCH_HB_US           300
`define TCH_US_PER_S        1000000

// detection arithmetic
`define TCH_DELTA_GAIN_HI   6
`define TCH_DELTA_GAIN_LO   12
`define TCH_HYST_PCT        17
`define TCH_PCT_FULL        100
`define TCH_INTEG_COUNT     3
// must outlast the three-stage synchroniser, else the reset level is caught
`define TCH_STRAP_SETTLE    6

// register offsets
`define TCH_REG_CTRL        4'h0
`define TCH_REG_STATUS      4'h4
`define TCH_REG_EVENT       4'h8
`define TCH_REG_HOLD        4'hC

// CTRL fields (write only)
`define TCH_CTRL_RECAL      0
`define TCH_CTRL_TOG_CLR    1

// STATUS fields
`define TCH_ST_DETECT       0
`define TCH_ST_OUT_ON       1
`define TCH_ST_HB_BUSY      2
`define TCH_ST_RECAL        3
`define TCH_ST_INTEG_LSB    4
`define TCH_ST_MODE_LSB     6
`define TCH_ST_GAIN_HI      8
`define TCH_ST_STRAPS_OK    9

// EVENT fields (write one to clear)
`define TCH_EV_TIMEOUT      0
`define TCH_EV_QUALIFY      1

`endif

// ==== tch_pkg.sv ====
package tch_pkg;

  typedef enum logic [1:0] {
    TCH_MODE_LEVEL_10,
    TCH_MODE_LEVEL_60,
    TCH_MODE_TOGGLE_10,
    TCH_MODE_LEVEL_INF
  } tch_mode_type;

  typedef enum logic [1:0] {
    TCH_ST_BOOT,
    TCH_ST_IDLE,
    TCH_ST_DETECT,
    TCH_ST_RECAL
  } tch_state_type;

endpackage

// ==== tch_sync.sv ====
`timescale 1ns/1ns
module tch_sync (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // asynchronous pin and its filtered level
  input  wire logic pin_i,
  output logic      level_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;

  // level only moves once the last two stages agree
  wire agree = (s2_q == s3_q);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      s3_q  <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree) begin
        lvl_q <= s3_q;
      end
    end
  end

  assign level_o = lvl_q;

endmodule // tch_sync

// ==== tch_pulse_timer.sv ====
`timescale 1ns/1ns
module tch_pulse_timer #(
  parameter int CYC = 30000,
  parameter int W   = 16
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // start pulse and busy window
  input  wire logic start_i,
  output logic      busy_o
);

  logic [W-1:0] cnt_q;
  logic         busy_q;

  localparam logic [W-1:0] LAST = W'(CYC - 1);

  if (CYC < 1 || CYC > (2 ** W)) begin : g_chk
    $error("tch_pulse_timer: CYC does not fit W");
  end

  wire at_end = (cnt_q == LAST);

  // a start while busy restarts the window
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else if (start_i) begin
      cnt_q  <= '0;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      cnt_q  <= at_end ? '0 : cnt_q + W'(1);
      busy_q <= !at_end;
    end
  end

  assign busy_o = busy_q;

endmodule // tch_pulse_timer

// ==== tch_output_ctrl_properties.sv ====
`timescale 1ns/1ns
module tch_output_ctrl_properties #(
  parameter bit     ACTIVE_HIGH    = 1'b0,
  parameter int     HB_CYC         = 30000,
  parameter longint HOLD_SHORT_CYC = 200,
  parameter longint HOLD_LONG_CYC  = 500
) (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // straps and bursts
  input wire logic        mode_strap_a_pin,
  input wire logic        mode_strap_b_pin,
  input wire logic        burst_done,
  // device outputs
  input wire logic        recal_req,
  input wire logic        out_o,
  input wire logic        out_oe,
  input wire logic        detect_active,
  // register port
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  int     hb_q;
  longint det_q;
  longint lim;
  wire    tog = !mode_strap_a_pin && !mode_strap_b_pin;
  wire    inf = !mode_strap_a_pin && mode_strap_b_pin;
  assign lim = (mode_strap_a_pin && !mode_strap_b_pin) ? HOLD_LONG_CYC : HOLD_SHORT_CYC;
  // saturating age of the last burst, so a restarted window is judged too
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hb_q  <= HB_CYC + 1;
      det_q <= 0;
    end else begin
      hb_q  <= burst_done ? 1 : ((hb_q > HB_CYC) ? hb_q : hb_q + 1);
      det_q <= detect_active ? det_q + 1 : 0;
    end
  end
  property p_hb_window;
    out_oe == (hb_q > HB_CYC);
  endproperty
  a_hb_window: assert property (p_hb_window)
    else $error("output release window wrong");
  property p_qualify;
    $rose(detect_active) |-> $past(burst_done);
  endproperty
  a_qualify: assert property (p_qualify)
    else $error("detection without a burst");
  property p_on_change;
    $rose(detect_active) |=> out_o != $past(out_o);
  endproperty
  a_on_change: assert property (p_on_change)
    else $error("output did not react to detection");
  property p_level_on;
    !tog && detect_active && $past(detect_active) |-> out_o == ACTIVE_HIGH;
  endproperty
  a_level_on: assert property (p_level_on)
    else $error("level output not active during detection");
  property p_level_off;
    !tog && !detect_active && !$past(detect_active) |-> out_o == !ACTIVE_HIGH;
  endproperty
  a_level_off: assert property (p_level_off)
    else $error("level output active without detection");
  property p_toggle_keep;
    tog && !detect_active && !$past(detect_active) && !$past(reg_wr) && !$past(reg_wr, 2)
      |-> $stable(out_o);
  endproperty
  a_toggle_keep: assert property (p_toggle_keep)
    else $error("toggle output changed without detection");
  property p_hold_bound;
    !inf |-> det_q <= lim + 1;
  endproperty
  a_hold_bound: assert property (p_hold_bound)
    else $error("detection outlived its hold limit");
  property p_no_recal_inf;
    inf && !$past(reg_wr) && !$past(reg_wr, 2) && !$past(reg_wr, 3) |-> !recal_req;
  endproperty
  a_no_recal_inf: assert property (p_no_recal_inf)
    else $error("recalibration without a hold limit");
  property p_recal_pulse;
    recal_req |=> !recal_req;
  endproperty
  a_recal_pulse: assert property (p_recal_pulse)
    else $error("recal request longer than one cycle");
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside the read cycle");
endmodule // tch_output_ctrl_properties

bind tch_output_ctrl tch_output_ctrl_properties #(
  .ACTIVE_HIGH(ACTIVE_HIGH), .HB_CYC(HB_CYC),
  .HOLD_SHORT_CYC(HOLD_SHORT_CYC), .HOLD_LONG_CYC(HOLD_LONG_CYC)
) u_props (
  .clk_sys(clk_sys), .rst(rst), .mode_strap_a_pin(mode_strap_a_pin),
  .mode_strap_b_pin(mode_strap_b_pin), .burst_done(burst_done), .recal_req(recal_req),
  .out_o(out_o), .out_oe(out_oe), .detect_active(detect_active),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
);

// ==== tch_host_model.sv ====
`timescale 1ns/1ns
module tch_host_model #(
  parameter int RECAL_DLY = 5
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // device pin and recal handshake
  input wire logic out_o,
  input wire logic out_oe,
  input wire logic recal_req,
  input wire logic slow,
  output logic     recal_done,
  output logic     pin_level
);
  logic last_q;
  int   wait_q;
  // load pulled opposite the last driven level, so a release shows in either state
  assign pin_level = out_oe ? out_o : !last_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      last_q     <= 1'b1;
      wait_q     <= 0;
      recal_done <= 1'b0;
    end else begin
      if (out_oe) last_q <= out_o;
      recal_done <= (wait_q == 1);
      if (recal_req) wait_q <= slow ? 40 : RECAL_DLY;
      else if (wait_q != 0) wait_q <= wait_q - 1;
    end
  end
endmodule // tch_host_model

// ==== touch_output_control_test.sv ====
`timescale 1ns/1ns
`include "tch_consts.svh"
module touch_output_control_test;
  localparam int HB = 8;
  logic        clk_sys, rst, strap_a, strap_b, gain, burst_done, reg_wr, reg_rd, slow;
  logic [15:0] sig, ref_lvl;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rdata;
  logic        recal_req, recal_done, out_o, out_oe, detect_active, pin_level;
  logic        out_hi, oe_hi;
  int          miscompares, check_count;

  tch_output_ctrl #(.HOLD_SHORT_CYC(200), .HOLD_LONG_CYC(500), .HB_CYC(HB)) dut (
    .clk_sys(clk_sys), .rst(rst), .mode_strap_a_pin(strap_a), .mode_strap_b_pin(strap_b),
    .gain_strap_pin(gain), .burst_done(burst_done), .burst_signal(sig),
    .burst_reference(ref_lvl), .recal_req(recal_req), .recal_done(recal_done),
    .out_o(out_o), .out_oe(out_oe), .detect_active(detect_active), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  tch_host_model host (.clk_sys(clk_sys), .rst(rst), .out_o(out_o), .out_oe(out_oe),
    .recal_req(recal_req), .slow(slow), .recal_done(recal_done), .pin_level(pin_level));
  // active-high variant on the same inputs, so only polarity may differ
  tch_output_ctrl #(.HOLD_SHORT_CYC(200), .HOLD_LONG_CYC(500), .HB_CYC(HB),
    .ACTIVE_HIGH(1'b1)) dut_hi (
    .clk_sys(clk_sys), .rst(rst), .mode_strap_a_pin(strap_a), .mode_strap_b_pin(strap_b),
    .gain_strap_pin(gain), .burst_done(burst_done), .burst_signal(sig),
    .burst_reference(ref_lvl), .recal_req(), .recal_done(recal_done),
    .out_o(out_hi), .out_oe(oe_hi), .detect_active(), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata());

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // every burst also checks the release window and what the load sees
  task automatic burst(input logic [15:0] s);
    @(posedge clk_sys);
    burst_done <= 1'b1; sig <= s;
    @(posedge clk_sys);
    burst_done <= 1'b0;
    #1 check(out_oe, 0);
    check(pin_level, !out_o);
    check(out_hi, !out_o);
    check(oe_hi, out_oe);
    repeat (HB) @(posedge clk_sys);
    #1 check(out_oe, 1);
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic bursts(input logic [15:0] s, input int n);
    repeat (n) burst(s);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // straps change only under reset and settle well before release
  task automatic do_reset(input logic a, input logic b, input logic g);
    rst <= 1'b1; strap_a <= a; strap_b <= b; gain <= g;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #300000;
    miscompares++;
    report_and_stop;
  end
  initial begin
    rst = 1'b1; strap_a = 1'b1; strap_b = 1'b1; gain = 1'b1; burst_done = 1'b0;
    reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 32'h0;
    sig = 16'h0; ref_lvl = 16'h0064; slow = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    wait_cyc(8);
    check(out_o, 1);
    for (int m = 0; m < 4; m++) begin
      do_reset(m < 2, m == 0 || m == 3, 1'b1);
      reg_read(`TCH_REG_STATUS, rdata);
      check(32'(rdata[`TCH_ST_MODE_LSB +: 2]), 32'(m));
    end
    reg_read(4'h2, rdata);
    check(rdata, 0);
    $display("test strap decode done");
    do_reset(1'b1, 1'b1, 1'b1);
    bursts(16'd107, 2); burst(16'd106); bursts(16'd107, 2);
    check(detect_active, 0);
    burst(16'd107);
    check(detect_active, 1); check(out_o, 0);
    burst(16'd105); check(out_o, 0);
    burst(16'd104); check(detect_active, 0); check(out_o, 1);
    bursts(16'd107, 3); wait_cyc(150); check(detect_active, 1);
    reg_read(`TCH_REG_HOLD, rdata);
    check(rdata, 32'hA);
    wait_cyc(60); check(detect_active, 0); check(out_o, 1);
    reg_read(`TCH_REG_EVENT, rdata);
    check(rdata, 32'h3);
    reg_write(`TCH_REG_EVENT, 32'h1);
    reg_read(`TCH_REG_EVENT, rdata);
    check(rdata, 32'h2);
    $display("test level short hold done");
    do_reset(1'b1, 1'b0, 1'b1);
    bursts(16'd107, 3); wait_cyc(300); check(detect_active, 1);
    wait_cyc(220); check(detect_active, 0);
    $display("test level long hold done");
    do_reset(1'b0, 1'b1, 1'b0);
    bursts(16'd112, 3); check(detect_active, 0);
    bursts(16'd113, 3); wait_cyc(600); check(detect_active, 1); check(out_o, 0);
    burst(16'd110); check(detect_active, 1);
    burst(16'd109); check(detect_active, 0); check(out_o, 1);
    bursts(16'd113, 3);
    reg_write(`TCH_REG_CTRL, 32'h1);
    wait_cyc(2);
    check(detect_active, 0);
    check(out_o, 1);
    $display("test no hold limit done");
    do_reset(1'b0, 1'b0, 1'b1);
    slow <= 1'b1;
    bursts(16'd107, 3); check(out_o, 0);
    burst(16'd100); check(detect_active, 0); check(out_o, 0);
    bursts(16'd107, 3); check(out_o, 1);
    burst(16'd100); bursts(16'd107, 3); check(out_o, 0);
    wait_cyc(150); check(detect_active, 1);
    wait_cyc(60); check(detect_active, 0); check(out_o, 0);
    reg_read(`TCH_REG_STATUS, rdata);
    check(rdata, 32'h38A);
    reg_write(`TCH_REG_CTRL, 32'h2); wait_cyc(3); check(out_o, 1);
    $display("test toggle done");
    report_and_stop;
  end
endmodule // touch_output_control_test
